// ==== shared/mlrb_pkg.sv ====
// Constants for the monitor limit register bank.
// Assumes a word-wide register command port on the device clock.
package mlrb_pkg;
  // Register command codes, as seen by the management host.
  localparam logic [7:0] ADDR_VOUT_LOW = 8'h43;
  localparam logic [7:0] ADDR_CURR_HIGH = 8'h4a;
  localparam logic [7:0] ADDR_TEMP_FAULT = 8'h4f;
  localparam logic [7:0] ADDR_TEMP_WARN = 8'h51;
  localparam logic [7:0] ADDR_VIN_HIGH = 8'h57;
  localparam logic [7:0] ADDR_VIN_LOW = 8'h58;
  localparam logic [7:0] ADDR_POWER_HIGH = 8'h6b;
  // Field widths of the stored thresholds.
  localparam int LIMIT_W = 12;
  localparam int POWER_W = 15;
  // Reset values of the threshold fields.
  localparam logic [11:0] RST_LOW = 12'h000;
  localparam logic [11:0] RST_HIGH = 12'hfff;
  localparam logic [14:0] RST_POWER = 15'h7fff;
  // Positions of the flags in the warning vector.
  localparam int FLG_VOUT_LOW = 0;
  localparam int FLG_CURR_HIGH = 1;
  localparam int FLG_TEMP_FAULT = 2;
  localparam int FLG_TEMP_WARN = 3;
  localparam int FLG_VIN_HIGH = 4;
  localparam int FLG_VIN_LOW = 5;
  localparam int FLG_POWER_HIGH = 6;
  localparam int FLG_W = 7;
endpackage

// ==== design/mlrb_limit_cell.sv ====
// One threshold register with a write port and a compare against a reading.
// Assumes the reading is in the same direct-format code as the threshold.
`timescale 1ns/10ps
module mlrb_limit_cell #(
  parameter int W = 12,
  parameter logic [W-1:0] RST = '0,
  parameter bit ABOVE = 1'b1
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Write strobe and data field.
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  // Reading to compare.
  input wire logic [W-1:0] reading,
  // Stored threshold and compare result.
  output logic [W-1:0] limit_q,
  output logic violate
);
  // Next threshold value.
  logic [W-1:0] nxt_limit;
  // Only the defined field is captured on a write.
  always_comb begin
    nxt_limit = limit_q;
    if (wr_en) begin
      nxt_limit = wr_data;
    end
  end
  // Threshold storage.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      limit_q <= RST;
    end else begin
      limit_q <= nxt_limit;
    end
  end
  // High limits trip above, low limits trip below.
  assign violate = ABOVE ? (reading > limit_q) : (reading < limit_q);
endmodule // mlrb_limit_cell

// ==== design/mlrb_limit_bank.sv ====
// What this block does
// - Output voltage low limit, 12 bits, resets zero.
// - Current high limit, 12 bits, resets all ones.
// - Temperature fault limit, 12 bits, resets ones.
// - Temperature warning limit, 12 bits, resets ones.
// - Input voltage high limit, resets all ones.
// - Input voltage low limit, resets to zero.
// - Power limit 15 bits, resets 0x7fff, bit15 zero.
// - Reserved upper bits always read as zero.
// - Limits share the readings' direct-format code.
// - Cleared warnings return if next conversion still violates.
//
// Register bank of monitor thresholds with warning flags.
// Assumes the host sequencer presents one word access per cycle and
// that each new conversion result comes with a one-cycle strobe.
`timescale 1ns/10ps
module mlrb_limit_bank
  import mlrb_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Register word access from the management interface.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  // Converted readings, direct format, with conversion strobe.
  input wire logic conv_done,
  input wire logic [11:0] vout_reading,
  input wire logic [11:0] vin_reading,
  input wire logic [11:0] curr_reading,
  input wire logic [11:0] temp_reading,
  input wire logic [14:0] power_reading,
  // Clear command for latched warnings.
  input wire logic clear_faults,
  // Latched warning flags.
  output logic [6:0] warn_flags,
  output logic overheat_fault_flag
);
  // Stored thresholds of each cell.
  logic [11:0] lim_vout_low, lim_curr_high, lim_temp_fault;
  logic [11:0] lim_temp_warn, lim_vin_high, lim_vin_low;
  logic [14:0] lim_power_high;
  // Raw compare results, one per cell.
  logic [FLG_W-1:0] viol;
  // Latched flags and their next value.
  logic [FLG_W-1:0] flags_ff, nxt_flags;
  // Read data register and its next value.
  logic [15:0] rdata_ff, nxt_rdata;

  // Each cell stores only its defined field of the written word.
  mlrb_limit_cell #(.W(LIMIT_W), .RST(RST_LOW), .ABOVE(1'b0)) u_vout_low (
    .mclk(mclk), .reset_n(reset_n),
    .wr_en(reg_wr && reg_addr == ADDR_VOUT_LOW),
    .wr_data(reg_wdata[11:0]),
    .reading(vout_reading),
    .limit_q(lim_vout_low), .violate(viol[FLG_VOUT_LOW]));
  mlrb_limit_cell #(.W(LIMIT_W), .RST(RST_HIGH), .ABOVE(1'b1)) u_curr_high (
    .mclk(mclk), .reset_n(reset_n),
    .wr_en(reg_wr && reg_addr == ADDR_CURR_HIGH),
    .wr_data(reg_wdata[11:0]),
    .reading(curr_reading),
    .limit_q(lim_curr_high), .violate(viol[FLG_CURR_HIGH]));
  mlrb_limit_cell #(.W(LIMIT_W), .RST(RST_HIGH), .ABOVE(1'b1)) u_temp_fault (
    .mclk(mclk), .reset_n(reset_n),
    .wr_en(reg_wr && reg_addr == ADDR_TEMP_FAULT),
    .wr_data(reg_wdata[11:0]),
    .reading(temp_reading),
    .limit_q(lim_temp_fault), .violate(viol[FLG_TEMP_FAULT]));
  mlrb_limit_cell #(.W(LIMIT_W), .RST(RST_HIGH), .ABOVE(1'b1)) u_temp_warn (
    .mclk(mclk), .reset_n(reset_n),
    .wr_en(reg_wr && reg_addr == ADDR_TEMP_WARN),
    .wr_data(reg_wdata[11:0]),
    .reading(temp_reading),
    .limit_q(lim_temp_warn), .violate(viol[FLG_TEMP_WARN]));
  mlrb_limit_cell #(.W(LIMIT_W), .RST(RST_HIGH), .ABOVE(1'b1)) u_vin_high (
    .mclk(mclk), .reset_n(reset_n),
    .wr_en(reg_wr && reg_addr == ADDR_VIN_HIGH),
    .wr_data(reg_wdata[11:0]),
    .reading(vin_reading),
    .limit_q(lim_vin_high), .violate(viol[FLG_VIN_HIGH]));
  mlrb_limit_cell #(.W(LIMIT_W), .RST(RST_LOW), .ABOVE(1'b0)) u_vin_low (
    .mclk(mclk), .reset_n(reset_n),
    .wr_en(reg_wr && reg_addr == ADDR_VIN_LOW),
    .wr_data(reg_wdata[11:0]),
    .reading(vin_reading),
    .limit_q(lim_vin_low), .violate(viol[FLG_VIN_LOW]));
  mlrb_limit_cell #(.W(POWER_W), .RST(RST_POWER), .ABOVE(1'b1)) u_pwr_high (
    .mclk(mclk), .reset_n(reset_n),
    .wr_en(reg_wr && reg_addr == ADDR_POWER_HIGH),
    .wr_data(reg_wdata[14:0]),
    .reading(power_reading),
    .limit_q(lim_power_high), .violate(viol[FLG_POWER_HIGH]));

  // Flags latch on a conversion; a clear drops them, but a violation seen
  // in the same conversion cycle wins so nothing is lost.
  always_comb begin
    nxt_flags = flags_ff;
    if (clear_faults) begin
      nxt_flags = '0;
    end
    if (conv_done) begin
      nxt_flags = nxt_flags | viol;
    end
  end
  // Flag storage.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Read mux; reserved upper bits are padded with zeros.
  always_comb begin
    nxt_rdata = 16'h0000;
    case (reg_addr)
      ADDR_VOUT_LOW: nxt_rdata = {4'h0, lim_vout_low};
      ADDR_CURR_HIGH: nxt_rdata = {4'h0, lim_curr_high};
      ADDR_TEMP_FAULT: nxt_rdata = {4'h0, lim_temp_fault};
      ADDR_TEMP_WARN: nxt_rdata = {4'h0, lim_temp_warn};
      ADDR_VIN_HIGH: nxt_rdata = {4'h0, lim_vin_high};
      ADDR_VIN_LOW: nxt_rdata = {4'h0, lim_vin_low};
      ADDR_POWER_HIGH: nxt_rdata = {1'b0, lim_power_high};
      default: nxt_rdata = 16'h0000;
    endcase
  end
  // Read data register, one cycle behind the address.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Hit is combinational from the address.
  always_comb begin
    case (reg_addr)
      ADDR_VOUT_LOW, ADDR_CURR_HIGH, ADDR_TEMP_FAULT, ADDR_TEMP_WARN,
      ADDR_VIN_HIGH, ADDR_VIN_LOW, ADDR_POWER_HIGH: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  end

  assign reg_rdata = rdata_ff;
  assign warn_flags = flags_ff;
  assign overheat_fault_flag = flags_ff[FLG_TEMP_FAULT];

  // Reserved upper nibble of twelve-bit registers never reads as one.
  a_resv_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(reg_addr) != ADDR_POWER_HIGH |-> reg_rdata[15:12] == 4'h0)
    else $error("reserved bits read nonzero");
  // Power register bit 15 always zero.
  a_power_msb: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_rdata[15] == 1'b0)
    else $error("power bit 15 nonzero");
  // A written current limit is stored masked to its 12-bit field.
  a_curr_wr: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == ADDR_CURR_HIGH |=> lim_curr_high == $past(reg_wdata[11:0]))
    else $error("current limit not stored");
  // Output low limit write.
  a_vout_wr: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == ADDR_VOUT_LOW |=> lim_vout_low == $past(reg_wdata[11:0]))
    else $error("vout limit not stored");
  // Readback of the vin low limit one cycle later.
  a_vin_low_rd: assert property (@(posedge mclk) disable iff (!reset_n)
    !reg_wr && reg_addr == ADDR_VIN_LOW |=> reg_rdata == {4'h0, lim_vin_low})
    else $error("vin low readback wrong");
  // Over-limit reading on a conversion sets the current flag.
  a_curr_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    conv_done && curr_reading > lim_curr_high |=> warn_flags[FLG_CURR_HIGH])
    else $error("overcurrent flag missed");
  // Under-limit vin reading sets the low flag.
  a_vin_low_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    conv_done && vin_reading < lim_vin_low |=> warn_flags[FLG_VIN_LOW])
    else $error("vin low flag missed");
  // Clear with no conversion drops every flag.
  a_clear_flags: assert property (@(posedge mclk) disable iff (!reset_n)
    clear_faults && !conv_done |=> warn_flags == 7'h00)
    else $error("clear did not drop flags");
  // Without a conversion a flag cannot newly rise.
  a_no_spont: assert property (@(posedge mclk) disable iff (!reset_n)
    !conv_done |=> (warn_flags & ~$past(warn_flags)) == 7'h00)
    else $error("flag rose without conversion");
  // Temperature fault limit stores writes.
  a_tfault_wr: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == ADDR_TEMP_FAULT |=> lim_temp_fault == $past(reg_wdata[11:0]))
    else $error("temp fault limit not stored");
  // Temperature warning limit stores writes.
  a_twarn_wr: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == ADDR_TEMP_WARN |=> lim_temp_warn == $past(reg_wdata[11:0]))
    else $error("temp warn limit not stored");
  // Vin high limit stores writes.
  a_vinh_wr: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == ADDR_VIN_HIGH |=> lim_vin_high == $past(reg_wdata[11:0]))
    else $error("vin high limit not stored");
endmodule // mlrb_limit_bank

// ==== testbench/mlrb_host_model.sv ====
// Host model that reads and writes the limit bank one word at a time.
// Assumes the bank samples its command port on the rising mclk edge.
`timescale 1ns/10ps
module mlrb_host_model (
  // Clock.
  input wire logic mclk,
  // Word access toward the bank.
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  // Idle port at time zero.
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end
  // One write pulse; the data is a direct-format code.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wr = 1'b1;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    // A released data bus must not keep the last word.
    reg_wdata = ~d;
  endtask
  // Present the code, then take the word one cycle later.
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    @(negedge mclk);
    d = reg_rdata;
  endtask
endmodule // mlrb_host_model

// ==== testbench/mlrb_limit_bank_tb.sv ====
// Self-checking bench for the monitor limit register bank.
// Assumes the host model and the bank share the 20 MHz clock.
`timescale 1ns/10ps
module mlrb_limit_bank_tb
  import mlrb_pkg::*;
;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic reg_hit, conv_done, clear_faults, overheat_fault_flag;
  logic [11:0] vout_r, vin_r, curr_r, temp_r;
  logic [14:0] power_r;
  logic [6:0] warn_flags;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  // Codes and reset words of the seven limits, in one order.
  logic [7:0] adr [7] = '{ADDR_VOUT_LOW, ADDR_CURR_HIGH, ADDR_TEMP_FAULT,
    ADDR_TEMP_WARN, ADDR_VIN_HIGH, ADDR_VIN_LOW, ADDR_POWER_HIGH};
  logic [15:0] rst [7] = '{16'h0000, 16'h0fff, 16'h0fff, 16'h0fff,
    16'h0fff, 16'h0000, 16'h7fff};
  // Clock of 50 ns period.
  always #25 mclk = ~mclk;
  mlrb_host_model i_mlrb_host_model (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  mlrb_limit_bank i_mlrb_limit_bank (.mclk(mclk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .conv_done(conv_done),
    .vout_reading(vout_r), .vin_reading(vin_r), .curr_reading(curr_r),
    .temp_reading(temp_r), .power_reading(power_r),
    .clear_faults(clear_faults), .warn_flags(warn_flags),
    .overheat_fault_flag(overheat_fault_flag));
  // Verdict and end of run.
  task automatic results();
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Compare of a register word.
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Compare of the flag byte, fault flag on top.
  task automatic chk_flag(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One conversion strobe or one clear pulse, then the flags.
  task automatic cv(input logic [11:0] v, c, t, vi, input logic [14:0] p,
    input logic clr, input logic [7:0] e);
    @(negedge mclk);
    {vout_r, curr_r, temp_r, vin_r, power_r} = {v, c, t, vi, p};
    conv_done = ~clr;
    clear_faults = clr;
    @(negedge mclk);
    conv_done = 1'b0;
    clear_faults = 1'b0;
    chk_flag({overheat_fault_flag, warn_flags}, e);
  endtask
  // A hung run is cut short as a mismatch.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      results();
    end
  end
  // Main sequence.
  initial begin
    {vout_r, curr_r, temp_r, vin_r, power_r} = '0;
    conv_done = 1'b0;
    clear_faults = 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    // Reset words and decode of every code.
    for (int i = 0; i < 7; i++) begin
      i_mlrb_host_model.rd(adr[i], d);
      chk_word(d, rst[i]);
      chk_flag({7'h00, reg_hit}, 8'h01);
    end
    // All ones written; reserved bits must come back clear.
    for (int i = 0; i < 7; i++) begin
      i_mlrb_host_model.wr(adr[i], 16'hffff);
      i_mlrb_host_model.rd(adr[i], d);
      chk_word(d, (i == 6) ? 16'h7fff : 16'h0fff);
    end
    // An unmapped code stores nothing and reads zero.
    i_mlrb_host_model.wr(8'h42, 16'h1234);
    i_mlrb_host_model.rd(8'h42, d);
    chk_word(d, 16'h0000);
    chk_flag({7'h00, reg_hit}, 8'h00);
    // Mid-scale limits; the fault limit sits above the warning.
    for (int i = 0; i < 7; i++) begin
      i_mlrb_host_model.wr(adr[i], (i == 6) ? 16'h4000 :
        (i == 2) ? 16'h0900 : 16'h0800);
    end
    // Equal readings trip nothing, strict compare.
    cv(12'h800, 12'h800, 12'h800, 12'h800, 15'h4000, 1'b0, 8'h00);
    cv(12'h7ff, 12'h801, 12'h801, 12'h801, 15'h4001, 1'b0, 8'h5b);
    // Flags stay latched over a clean conversion.
    cv(12'h800, 12'h800, 12'h800, 12'h800, 15'h4000, 1'b0, 8'h5b);
    cv(12'h7ff, 12'h801, 12'h801, 12'h801, 15'h4001, 1'b1, 8'h00);
    // A still violated limit sets its flag again.
    cv(12'h7ff, 12'h801, 12'h801, 12'h801, 15'h4001, 1'b0, 8'h5b);
    cv(12'h800, 12'h800, 12'h800, 12'h800, 15'h4000, 1'b1, 8'h00);
    cv(12'h800, 12'h800, 12'h901, 12'h7ff, 15'h4000, 1'b0, 8'hac);
    results();
  end
endmodule // mlrb_limit_bank_tb
